//--- verilog/uart_queue_pkg.sv
`default_nettype none
package uart_queue_pkg;
    // register offsets; printed offsets are not all multiples of four, so byte address = 4 * index
    localparam logic [7:0] IDX_QUEUE_DATA = 8'h03;
    localparam logic [7:0] IDX_RX_FILL = 8'h10;
    localparam logic [7:0] IDX_TX_FREE = 8'h11;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h25;
    localparam logic [7:0] IDX_RX_THRESH = 8'h46;
    localparam logic [7:0] IDX_TX_THRESH = 8'h47;
    localparam logic [7:0] IDX_CHAN_STATUS = 8'h01;
    localparam logic [7:0] IDX_COMMAND = 8'h02;
    localparam logic [7:0] IDX_MODE = 8'h04;
    localparam logic [7:0] IDX_SOURCE_STATUS = 8'h05;
    localparam logic [7:0] CMD_RESET_ERROR = 8'h04;
    // reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] RX_THRESH_RESET = 8'h01;
    localparam logic [7:0] TX_THRESH_RESET = 8'h00;
    localparam logic [3:0] MODE_RESET = 4'h3;
    // field positions
    localparam int SRC_TX = 0;
    localparam int SRC_RX = 1;
    localparam int SRC_BREAK = 2;
    localparam int SRC_TIMER = 3;
    localparam int SRC_FLOW = 4;
    localparam int SRC_ADDR = 5;
    localparam int SRC_WATCHDOG = 6;
    localparam int SRC_CHANGE = 7;
    localparam int ENTRY_PARITY = 8;
    localparam int ENTRY_FRAMING = 9;
    localparam int ENTRY_BREAK = 10;
    localparam int MODE_BLOCK_ERR = 2;
    localparam int DEPTH = 256;
    localparam int PTR_W = 8;
    localparam int CNT_W = 9;
    localparam logic [6:0] IDLE_BIT_TIMES = 7'h40;
    typedef struct packed {
        logic [2:0] err;
        logic [7:0] data;
    } rx_entry_t;
    typedef struct packed {
        logic change;
        logic watchdog_bit;
        logic addr_change;
        logic flow_char;
        logic timer_zero;
        logic brk;
    } events_t;
endpackage : uart_queue_pkg
`default_nettype wire

//--- verilog/uart_queue.sv
// Operation
// - status bit reaches arbitration only when it and its mask bit are set; low irq.
// - mask bit 7 lets input change detection raise an interrupt.
// - mask bit 6 lets 64 idle receive bit times raise an interrupt.
// - mask bit 5 lets address recognition state changes raise an interrupt.
// - mask bit 4 lets flow-control character recognition raise an interrupt.
// - mask bit 3 lets counter/timer reaching zero raise an interrupt.
// - mask bit 2 lets receiver break detection raise an interrupt.
// - mask bit 1 lets receive queue service request raise an interrupt.
// - mask bit 0 lets transmit queue service request raise an interrupt.
// - receive queue is 256 entries of 11 bits, status travels with byte.
// - entry bits 10..8 break, framing, parity update status on each read.
// - block error mode accumulates errors since reset-error command 0x04.
// - bits 7:0 drive read data; unused upper bits read zero.
// - transmit queue is 256 entries of 8 bits.
// - bits above character length are dropped from transmitted bytes.
// - receive threshold picks fill level; writing it overrides mode level.
// - transmit threshold picks empty level; writing it overrides mode level.
// - fill count shows 1..255; zero means 256 if data present, else empty.
// - free count shows 1..255; zero means 256 if space present, else none.
// - character compare registers do nothing by themselves.
// - receive service bit set while fill meets or exceeds level.
// - transmit service bit set while free space meets or exceeds level.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module uart_queue (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive shift side
    input wire logic rx_valid,
    input wire uart_queue_pkg::rx_entry_t rx_entry,
    output logic rx_ready,
    input wire logic rx_bit_tick,
    input wire logic rx_line_idle,
    // transmit shift side
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_take,
    // event sources, same clock
    input wire uart_queue_pkg::events_t events,
    // interrupt
    output logic irq_out_n
);
    // mode: [1:0] char length code 0..3 = 5..8 bits, [2] block error mode
    logic [3:0] mode_register_one_q;
    logic [7:0] interrupt_enable_mask_q;
    logic [7:0] receive_irq_threshold_q;
    logic [7:0] transmit_irq_threshold_q;
    logic [7:0] interrupt_source_status;
    logic [2:0] err_status_q;
    logic [6:0] idle_cnt_q;
    logic watchdog_q;
    uart_queue_pkg::rx_entry_t rx_mem [0:uart_queue_pkg::DEPTH-1];
    logic [7:0] tx_mem [0:uart_queue_pkg::DEPTH-1];
    logic [uart_queue_pkg::PTR_W-1:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q;
    logic [uart_queue_pkg::CNT_W-1:0] rx_cnt_q, tx_cnt_q;
    logic [7:0] char_mask;

    // apb decode
    logic [7:0] idx;
    logic acc, wr, rd, mapped;
    assign idx = paddr[9:2];
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    always_comb begin
        if (paddr[31:10] != 22'h000000 || paddr[1:0] != 2'h0) mapped = 1'b0;
        else if (idx == uart_queue_pkg::IDX_QUEUE_DATA) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_RX_FILL) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_TX_FREE) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_IRQ_MASK) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_RX_THRESH) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_TX_THRESH) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_CHAN_STATUS) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_COMMAND) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_MODE) mapped = 1'b1;
        else if (idx == uart_queue_pkg::IDX_SOURCE_STATUS) mapped = 1'b1;
        else mapped = 1'b0;
    end

    logic data_sel, rx_pop, tx_push, rx_push, tx_pop;
    assign data_sel = mapped && idx == uart_queue_pkg::IDX_QUEUE_DATA;
    assign rx_pop = rd && data_sel && rx_cnt_q != 9'h000;
    assign tx_push = wr && data_sel && tx_cnt_q != 9'h100;
    assign rx_push = rx_valid && rx_ready;
    assign tx_pop = tx_valid && tx_take;

    // one wait state per access: setup, access with pready low, access with pready high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pready <= 1'b0;
        else pready <= psel && penable && !pready;
    end

    // receive queue; the error bits ride along with each byte
    always_ff @(posedge pclk) begin
        if (rx_push) rx_mem[rx_wr_q] <= rx_entry;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wr_q <= 8'h00;
            rx_rd_q <= 8'h00;
            rx_cnt_q <= 9'h000;
        end else begin
            if (rx_push) rx_wr_q <= rx_wr_q + 8'h01;
            if (rx_pop) rx_rd_q <= rx_rd_q + 8'h01;
            rx_cnt_q <= rx_cnt_q + {8'h00, rx_push} - {8'h00, rx_pop};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rx_ready <= 1'b1;
        else rx_ready <= (rx_cnt_q + {8'h00, rx_push} - {8'h00, rx_pop}) != 9'h100;
    end

    // transmit queue
    always_ff @(posedge pclk) begin
        if (tx_push) tx_mem[tx_wr_q] <= pwdata[7:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wr_q <= 8'h00;
            tx_rd_q <= 8'h00;
            tx_cnt_q <= 9'h000;
        end else begin
            if (tx_push) tx_wr_q <= tx_wr_q + 8'h01;
            if (tx_pop) tx_rd_q <= tx_rd_q + 8'h01;
            tx_cnt_q <= tx_cnt_q + {8'h00, tx_push} - {8'h00, tx_pop};
        end
    end
    // head word presented registered; refreshed whenever pointer or contents move
    logic [uart_queue_pkg::PTR_W-1:0] tx_head_ptr;
    logic [uart_queue_pkg::CNT_W-1:0] tx_cnt_d;
    assign tx_head_ptr = tx_pop ? tx_rd_q + 8'h01 : tx_rd_q;
    assign tx_cnt_d = tx_cnt_q + {8'h00, tx_push} - {8'h00, tx_pop};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            tx_valid <= tx_cnt_d != 9'h000;
            if (tx_push && tx_cnt_d == 9'h001) tx_data <= pwdata[7:0] & char_mask;
            else tx_data <= tx_mem[tx_head_ptr] & char_mask;
        end
    end

    // length code 0..3 = 5..8 bits; upper bits dropped
    always_comb begin
        case (mode_register_one_q[1:0])
            2'h0: char_mask = 8'h1F;
            2'h1: char_mask = 8'h3F;
            2'h2: char_mask = 8'h7F;
            default: char_mask = 8'hFF;
        endcase
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_register_one_q <= uart_queue_pkg::MODE_RESET;
            interrupt_enable_mask_q <= uart_queue_pkg::MASK_RESET;
            receive_irq_threshold_q <= uart_queue_pkg::RX_THRESH_RESET;
            transmit_irq_threshold_q <= uart_queue_pkg::TX_THRESH_RESET;
        end else if (wr && mapped) begin
            if (idx == uart_queue_pkg::IDX_MODE) mode_register_one_q <= pwdata[3:0];
            else if (idx == uart_queue_pkg::IDX_IRQ_MASK) interrupt_enable_mask_q <= pwdata[7:0];
            else if (idx == uart_queue_pkg::IDX_RX_THRESH) receive_irq_threshold_q <= pwdata[7:0];
            else if (idx == uart_queue_pkg::IDX_TX_THRESH) transmit_irq_threshold_q <= pwdata[7:0];
        end
    end

    // error status: per-character on each pop, or sticky accumulation in block mode
    logic reset_err_cmd;
    assign reset_err_cmd = wr && mapped && idx == uart_queue_pkg::IDX_COMMAND
        && pwdata[7:0] == uart_queue_pkg::CMD_RESET_ERROR;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) err_status_q <= 3'h0;
        else if (mode_register_one_q[uart_queue_pkg::MODE_BLOCK_ERR]) begin
            // set beats the clear so an error arriving with the command is kept
            if (rx_push) err_status_q <= (reset_err_cmd ? 3'h0 : err_status_q) | rx_entry.err;
            else if (reset_err_cmd) err_status_q <= 3'h0;
        end else if (rx_pop) err_status_q <= rx_mem[rx_rd_q].err;
        else if (reset_err_cmd) err_status_q <= 3'h0;
    end

    // receive watchdog: 64 idle bit times
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_q <= 7'h00;
            watchdog_q <= 1'b0;
        end else begin
            if (!rx_line_idle || rx_push) idle_cnt_q <= 7'h00;
            else if (rx_bit_tick && idle_cnt_q != uart_queue_pkg::IDLE_BIT_TIMES) idle_cnt_q <= idle_cnt_q + 7'h01;
            if (rx_bit_tick && rx_line_idle && idle_cnt_q == uart_queue_pkg::IDLE_BIT_TIMES - 7'h01) begin
                watchdog_q <= 1'b1;
            end else if (rx_pop || rx_push) begin
                watchdog_q <= 1'b0;
            end
        end
    end

    // service levels; threshold 0 stands for 256
    logic rx_service, tx_service;
    logic [8:0] rx_level, tx_level;
    assign rx_level = receive_irq_threshold_q == 8'h00 ? 9'h100 : {1'b0, receive_irq_threshold_q};
    assign tx_level = transmit_irq_threshold_q == 8'h00 ? 9'h100 : {1'b0, transmit_irq_threshold_q};
    assign rx_service = rx_cnt_q >= rx_level;
    assign tx_service = (9'h100 - tx_cnt_q) >= tx_level;
    assign interrupt_source_status = {events.change, watchdog_q | events.watchdog_bit, events.addr_change,
        events.flow_char, events.timer_zero, events.brk, rx_service, tx_service};

    // arbitration reduced to an OR of enabled sources; compare registers add nothing here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_out_n <= 1'b1;
        else irq_out_n <= ~|(interrupt_source_status & interrupt_enable_mask_q);
    end

    // read data
    logic [31:0] rdata_d;
    logic has_data, has_space;
    assign has_data = rx_cnt_q != 9'h000;
    assign has_space = tx_cnt_q != 9'h100;
    // character mode shows the head byte's errors, so status read before the pop describes that byte
    logic [2:0] shown_err;
    assign shown_err = mode_register_one_q[uart_queue_pkg::MODE_BLOCK_ERR] ? err_status_q
        : (has_data ? rx_mem[rx_rd_q].err : 3'h0);
    always_comb begin
        rdata_d = 32'h00000000;
        if (idx == uart_queue_pkg::IDX_QUEUE_DATA) rdata_d[7:0] = rx_mem[rx_rd_q].data & char_mask;
        else if (idx == uart_queue_pkg::IDX_RX_FILL) rdata_d[7:0] = rx_cnt_q[7:0];
        else if (idx == uart_queue_pkg::IDX_TX_FREE) rdata_d[7:0] = 8'(9'h100 - tx_cnt_q);
        else if (idx == uart_queue_pkg::IDX_IRQ_MASK) rdata_d[7:0] = interrupt_enable_mask_q;
        else if (idx == uart_queue_pkg::IDX_RX_THRESH) rdata_d[7:0] = receive_irq_threshold_q;
        else if (idx == uart_queue_pkg::IDX_TX_THRESH) rdata_d[7:0] = transmit_irq_threshold_q;
        else if (idx == uart_queue_pkg::IDX_CHAN_STATUS) rdata_d[4:0] = {shown_err, has_space, has_data};
        else if (idx == uart_queue_pkg::IDX_MODE) rdata_d[3:0] = mode_register_one_q;
        else if (idx == uart_queue_pkg::IDX_SOURCE_STATUS) rdata_d[7:0] = interrupt_source_status;
        if (!mapped) rdata_d = 32'h00000000;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && penable && !pready && !pwrite) ? rdata_d : 32'h00000000;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    // checks
    a_irq_follows_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (interrupt_source_status & interrupt_enable_mask_q) == 8'h00 |=> irq_out_n)
        else $error("irq asserted with nothing enabled");
    a_irq_asserts: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_service && interrupt_enable_mask_q[1]) |=> !irq_out_n)
        else $error("receive service did not raise irq");
    a_tx_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_service && interrupt_enable_mask_q[0]) |=> !irq_out_n)
        else $error("transmit service did not raise irq");
    a_rx_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
        rx_cnt_q <= 9'h100)
        else $error("receive count overflow");
    a_tx_full_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_cnt_q == 9'h100 && !tx_pop) |=> tx_cnt_q == 9'h100)
        else $error("full transmit queue changed");
    a_rx_level_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        rx_service == (rx_cnt_q >= rx_level))
        else $error("receive service level wrong");
    a_tx_data_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_data & ~char_mask) == 8'h00 || $changed(mode_register_one_q))
        else $error("transmit data upper bits not dropped");
    a_pop_count: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_pop && !rx_push) |=> rx_cnt_q == $past(rx_cnt_q) - 9'h001)
        else $error("receive pop did not decrement");
    a_block_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_register_one_q[2] && err_status_q[0] && !reset_err_cmd && $stable(mode_register_one_q))
        |=> err_status_q[0])
        else $error("block error lost");
    a_watchdog_set: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_bit_tick && rx_line_idle && idle_cnt_q == 7'h3F && !rx_push) |=> watchdog_q)
        else $error("watchdog missed");
    c_rx_full: cover property (@(posedge pclk) disable iff (!presetn) rx_cnt_q == 9'h100);
    c_tx_full_write: cover property (@(posedge pclk) disable iff (!presetn) wr && data_sel && tx_cnt_q == 9'h100);
    c_irq_low: cover property (@(posedge pclk) disable iff (!presetn) !irq_out_n);
    c_watchdog: cover property (@(posedge pclk) disable iff (!presetn) watchdog_q);
endmodule : uart_queue
`default_nettype wire

//--- bench/uart_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module uart_line_model (
    // clock
    input wire logic pclk,
    // receive shift side
    output logic rx_valid,
    output uart_queue_pkg::rx_entry_t rx_entry,
    input wire logic rx_ready,
    // transmit shift side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_take,
    input wire logic sink_en
);
    uart_queue_pkg::rx_entry_t pend[$];
    logic [7:0] got[$];
    logic [1:0] gap_q = 2'h0;
    initial begin
        rx_valid = 1'b0;
        rx_entry = '0;
        tx_take = 1'b0;
    end
    // idle entry lines show inverted bits so a stale word never looks like data
    always @(posedge pclk) begin
        if (rx_valid && rx_ready) begin
            pend.delete(0);
        end
        rx_valid <= (pend.size() > 0);
        rx_entry <= (pend.size() > 0) ? pend[0] : ~rx_entry;
        tx_take <= 1'b0;
        gap_q <= (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
        // gap leaves room for the head to refresh after each pop
        if (sink_en && tx_valid && gap_q == 2'h0) begin
            tx_take <= 1'b1;
            gap_q <= 2'h3;
            got.push_back(tx_data);
        end
    end
endmodule : uart_line_model
`default_nettype wire

//--- bench/tb_uart_fifo_levels_and_irq_mask.sv
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_levels_and_irq_mask;
    localparam logic [7:0] A_DAT = uart_queue_pkg::IDX_QUEUE_DATA;
    localparam logic [7:0] A_FIL = uart_queue_pkg::IDX_RX_FILL;
    localparam logic [7:0] A_FRE = uart_queue_pkg::IDX_TX_FREE;
    localparam logic [7:0] A_MSK = uart_queue_pkg::IDX_IRQ_MASK;
    localparam logic [7:0] A_RTH = uart_queue_pkg::IDX_RX_THRESH;
    localparam logic [7:0] A_TTH = uart_queue_pkg::IDX_TX_THRESH;
    localparam logic [7:0] A_STA = uart_queue_pkg::IDX_CHAN_STATUS;
    localparam logic [7:0] A_MOD = uart_queue_pkg::IDX_MODE;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic rx_bit_tick = 1'b0;
    logic rx_line_idle = 1'b0;
    logic sink_en = 1'b0;
    uart_queue_pkg::events_t events = '0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_take, irq_out_n;
    logic [7:0] tx_data;
    uart_queue_pkg::rx_entry_t rx_entry;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] ridx [5] = '{A_MSK, A_RTH, A_TTH, A_FIL, A_FRE};
    logic [7:0] rexp [5] = '{uart_queue_pkg::MASK_RESET, uart_queue_pkg::RX_THRESH_RESET,
                             uart_queue_pkg::TX_THRESH_RESET, 8'h00, 8'h00};
    always #2.5 pclk = ~pclk;
    uart_queue dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_entry(rx_entry), .rx_ready(rx_ready), .rx_bit_tick(rx_bit_tick),
        .rx_line_idle(rx_line_idle), .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take),
        .events(events), .irq_out_n(irq_out_n));
    uart_line_model model (.pclk(pclk), .rx_valid(rx_valid), .rx_entry(rx_entry), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take), .sink_en(sink_en));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // one full apb transfer; never assumes how soon pready comes
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic irq(input logic exp);
        repeat (4) @(posedge pclk);
        check({31'h0, irq_out_n}, {31'h0, exp});
    endtask : irq
    task automatic push(input logic [2:0] e, input logic [7:0] d);
        model.pend.push_back(uart_queue_pkg::rx_entry_t'({e, d}));
    endtask : push
    task automatic tick;
        @(posedge pclk);
        rx_bit_tick <= 1'b1;
        @(posedge pclk);
        rx_bit_tick <= 1'b0;
    endtask : tick
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ridx[i]) begin
            apb(1'b0, ridx[i], 32'h0);
            check(rd, {24'h0, rexp[i]});
        end
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h3, 32'h2);
        irq(1'b1);
        apb(1'b0, 8'h7F, 32'h0);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, A_MSK, 32'hA5);
        apb(1'b0, A_MSK, 32'h0);
        check(rd, 32'hA5);
        // watchdog source is counted inside, so slot 4 is skipped here
        for (int j = 0; j < 6; j++) begin
            if (j != 4) begin
                apb(1'b1, A_MSK, 32'h0);
                events <= uart_queue_pkg::events_t'(6'h1 << j);
                irq(1'b1);
                apb(1'b1, A_MSK, 32'h4 << j);
                irq(1'b0);
                events <= '0;
            end
        end
        apb(1'b1, A_MSK, 32'h40);
        push(3'h0, 8'h11);
        repeat (4) @(posedge pclk);
        rx_line_idle <= 1'b1;
        repeat (63) tick();
        irq(1'b1);
        tick();
        irq(1'b0);
        rx_line_idle <= 1'b0;
        apb(1'b0, A_DAT, 32'h0);
        check(rd, 32'h11);
        apb(1'b1, A_MSK, 32'h2);
        apb(1'b1, A_RTH, 32'h2);
        push(3'b100, 8'h5A);
        irq(1'b1);
        push(3'b011, 8'hC3);
        irq(1'b0);
        apb(1'b0, A_FIL, 32'h0);
        check(rd, 32'h2);
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h1C, 32'h10);
        apb(1'b0, A_DAT, 32'h0);
        check(rd, 32'h5A);
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h1C, 32'h0C);
        apb(1'b0, A_DAT, 32'h0);
        check(rd, 32'hC3);
        irq(1'b1);
        apb(1'b1, A_MOD, 32'h0);
        push(3'h0, 8'hFF);
        repeat (4) @(posedge pclk);
        apb(1'b0, A_DAT, 32'h0);
        check(rd, 32'h1F);
        apb(1'b1, A_DAT, 32'hFF);
        sink_en <= 1'b1;
        repeat (10) @(posedge pclk);
        check({24'h0, model.got[0]}, 32'h1F);
        sink_en <= 1'b0;
        model.got.delete();
        apb(1'b1, A_MOD, 32'h7);
        push(3'b001, 8'h01);
        push(3'h0, 8'h02);
        repeat (4) @(posedge pclk);
        apb(1'b0, A_DAT, 32'h0);
        apb(1'b0, A_DAT, 32'h0);
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h1C, 32'h04);
        apb(1'b1, uart_queue_pkg::IDX_COMMAND, {24'h0, uart_queue_pkg::CMD_RESET_ERROR});
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h1C, 32'h0);
        apb(1'b1, A_MOD, 32'h3);
        for (int i = 0; i < 256; i++) push(3'h0, i[7:0]);
        for (int n = 0; n < 600 && rx_ready !== 1'b0; n++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        check({31'h0, rx_ready}, 32'h0);
        apb(1'b0, A_FIL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h1, 32'h1);
        for (int i = 0; i < 256; i++) begin
            apb(1'b0, A_DAT, 32'h0);
            check(rd, i);
        end
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h1, 32'h0);
        apb(1'b1, A_MSK, 32'h1);
        apb(1'b1, A_TTH, 32'h0);
        irq(1'b0);
        for (int i = 0; i < 257; i++) apb(1'b1, A_DAT, (i < 256) ? (i ^ 32'h5A) : 32'hEE);
        apb(1'b0, A_FRE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h2, 32'h0);
        irq(1'b1);
        apb(1'b1, A_TTH, 32'h10);
        sink_en <= 1'b1;
        for (int n = 0; n < 200 && model.got.size() < 16; n++) @(negedge pclk);
        @(posedge pclk);
        sink_en <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, A_FRE, 32'h0);
        check(rd, 32'h10);
        irq(1'b0);
        sink_en <= 1'b1;
        for (int n = 0; n < 1500 && model.got.size() < 256; n++) @(negedge pclk);
        repeat (20) @(posedge pclk);
        check(model.got.size(), 32'd256);
        foreach (model.got[i]) check({24'h0, model.got[i]}, i ^ 32'h5A);
        apb(1'b0, A_STA, 32'h0);
        check(rd & 32'h2, 32'h2);
        conclude();
    end
endmodule : tb_uart_fifo_levels_and_irq_mask
`default_nettype wire
